// ### shared/led_dim_pkg.sv
// Constants, types and helpers for the power-on LED dimming settings block
// What this block does
// R1 - Four settings registers at 13h, 15h, 17h, 19h for LED groups 0, 1-3, 4-6, 7-9
// R2 - Bits 7:6 pick ramp-down time from fade time one to four
// R3 - Bits 5:3 pick low-brightness intensity, 0% up to 100%
// R4 - Bits 2:1 pick high-brightness time from the four fade times
// R5 - Bit 0 sets the low-brightness time of the group
// R6 - All LEDs of a group follow that register's fields during the effect
package led_dim_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] REG_OUT0_OFS    = 8'h13;
    localparam logic [7:0] REG_OUT1TO3_OFS = 8'h15;
    localparam logic [7:0] REG_OUT4TO6_OFS = 8'h17;
    localparam logic [7:0] REG_OUT7TO9_OFS = 8'h19;
    localparam logic [7:0] CFG_RESET       = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // Field positions
    localparam int TRD_MSB = 7;
    localparam int TRD_LSB = 6;
    localparam int LOW_MSB = 5;
    localparam int LOW_LSB = 3;
    localparam int TH_MSB  = 2;
    localparam int TH_LSB  = 1;
    localparam int TL_BIT  = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes and timing
    localparam int         GROUPS       = 4;
    localparam int         LEDS         = 10;
    localparam int         FADE_W       = 16;
    localparam logic [6:0] PWM_LAST     = 7'h63;
    localparam logic [6:0] FULL_LEVEL   = 7'h64;
    localparam int         CLK_KHZ      = 10000;
    localparam int         TICK_TIME_MS = 1;
    localparam int         TICK_CYCLES  = TICK_TIME_MS * CLK_KHZ;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;

    typedef enum {I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
                  I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK} i2c_state_t;
    typedef enum {EFF_OFF, EFF_HIGH, EFF_RAMP, EFF_LOW} eff_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [6:0] low_percent(input logic [2:0] code);
        case (code)
            3'h0:    low_percent = 7'h00;
            3'h1:    low_percent = 7'h0a;
            3'h2:    low_percent = 7'h14;
            3'h3:    low_percent = 7'h1e;
            3'h4:    low_percent = 7'h28;
            3'h5:    low_percent = 7'h3c;
            3'h6:    low_percent = 7'h50;
            default: low_percent = 7'h64;
        endcase
    endfunction

    // Valid flag above a two-bit register index
    function automatic logic [2:0] reg_slot(input logic [7:0] a);
        case (a)
            REG_OUT0_OFS:    reg_slot = 3'h4;
            REG_OUT1TO3_OFS: reg_slot = 3'h5;
            REG_OUT4TO6_OFS: reg_slot = 3'h6;
            REG_OUT7TO9_OFS: reg_slot = 3'h7;
            default:         reg_slot = 3'h0;
        endcase
    endfunction

    function automatic logic [1:0] led_group(input int i);
        if (i == 0) begin
            led_group = 2'h0;
        end else if (i <= 3) begin
            led_group = 2'h1;
        end else if (i <= 6) begin
            led_group = 2'h2;
        end else begin
            led_group = 2'h3;
        end
    endfunction

endpackage

// ### shared/effect_if.sv
// Link between the settings block and one group's effect engine
interface effect_if;
    logic [7:0]                          cfg;
    logic [3:0][led_dim_pkg::FADE_W-1:0] fade;
    logic                                tick;
    logic                                start;
    logic [6:0]                          level;
    logic                                busy;

    modport ctrl (output cfg, output fade, output tick, output start,
                  input level, input busy);
    modport eng  (input cfg, input fade, input tick, input start,
                  output level, output busy);
endinterface

// ### rtl/dim_effect_engine.sv
// Power-on dimming sequence for one LED group
module dim_effect_engine
    import led_dim_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    effect_if.eng    bus
);
    import led_dim_pkg::*;

    eff_state_t         state_reg;
    logic [FADE_W-1:0]  timer_reg;
    logic [FADE_W:0]    acc_reg;
    logic [6:0]         level_reg;
    logic [6:0]         low_lvl;
    logic [6:0]         span;
    logic [FADE_W-1:0]  t_rd;
    logic [FADE_W-1:0]  t_h;
    logic [FADE_W-1:0]  t_l;
    logic [FADE_W:0]    sum;

    ////////////////////////////////////////////////////////////////////////////////
    // Field decode
    assign t_rd    = bus.fade[bus.cfg[TRD_MSB:TRD_LSB]];           // see R2
    assign low_lvl = low_percent(bus.cfg[LOW_MSB:LOW_LSB]);        // see R3
    assign t_h     = bus.fade[bus.cfg[TH_MSB:TH_LSB]];             // see R4
    assign t_l     = bus.fade[{1'b0, bus.cfg[TL_BIT]}];            // see R5
    assign span    = 7'(FULL_LEVEL - low_lvl);
    assign sum     = 17'(acc_reg + {10'h000, span});

    ////////////////////////////////////////////////////////////////////////////////
    // Sequence: high, ramp down, low, off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= EFF_OFF;
            timer_reg <= '0;
            acc_reg   <= '0;
            level_reg <= 7'h00;
        end else if (bus.start) begin
            state_reg <= EFF_HIGH;
            timer_reg <= t_h;                                      // see R4
            acc_reg   <= '0;
            level_reg <= FULL_LEVEL;
        end else if (bus.tick) begin
            case (state_reg)
                EFF_HIGH: begin
                    if (timer_reg <= 16'h0001) begin
                        state_reg <= EFF_RAMP;
                        timer_reg <= t_rd;                         // see R2
                        acc_reg   <= '0;
                    end else begin
                        timer_reg <= 16'(timer_reg - 16'h0001);
                    end
                end
                EFF_RAMP: begin
                    if (timer_reg <= 16'h0001) begin
                        state_reg <= EFF_LOW;
                        level_reg <= low_lvl;                      // see R3
                        timer_reg <= t_l;                          // see R5
                    end else begin
                        timer_reg <= 16'(timer_reg - 16'h0001);
                        if (sum >= {1'b0, t_rd}) begin
                            acc_reg <= 17'(sum - {1'b0, t_rd});
                            if (level_reg > low_lvl) begin
                                level_reg <= 7'(level_reg - 7'h01);
                            end
                        end else begin
                            acc_reg <= sum;
                        end
                    end
                end
                EFF_LOW: begin
                    if (timer_reg <= 16'h0001) begin
                        state_reg <= EFF_OFF;
                        level_reg <= 7'h00;
                    end else begin
                        timer_reg <= 16'(timer_reg - 16'h0001);
                    end
                end
                default: begin
                    level_reg <= 7'h00;
                end
            endcase
        end
    end

    assign bus.level = level_reg;
    assign bus.busy  = (state_reg != EFF_OFF);

endmodule // dim_effect_engine

// ### rtl/led_power_on_dim_config.sv
// Serial-link settings registers and LED drive for the power-on dimming effect
module led_power_on_dim_config #(
    parameter int         TICK_CYCLES_P = led_dim_pkg::TICK_CYCLES,
    parameter logic [6:0] DEV_ADDR      = led_dim_pkg::DEV_ADDR_DEF
) (
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         scl,
    input  wire logic                         sda_in,
    output wire logic                         sda_out,
    output wire logic                         sda_oe,
    input  wire logic                         effect_start,
    input  wire logic [led_dim_pkg::FADE_W-1:0] fade_time_one,
    input  wire logic [led_dim_pkg::FADE_W-1:0] fade_time_two,
    input  wire logic [led_dim_pkg::FADE_W-1:0] fade_time_three,
    input  wire logic [led_dim_pkg::FADE_W-1:0] fade_time_four,
    output wire logic [led_dim_pkg::LEDS-1:0]   led_output,
    output wire logic [led_dim_pkg::GROUPS-1:0] effect_busy
);
    import led_dim_pkg::*;

    logic              scl_d;
    logic              sda_d;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    i2c_state_t        state_reg;
    logic [3:0]        bit_cnt_reg;
    logic [7:0]        shift_reg;
    logic [7:0]        tx_reg;
    logic [7:0]        ptr_reg;
    logic [7:0]        ptr_inc;
    logic [7:0]        rd_cur;
    logic [7:0]        rd_inc;
    logic              oe_reg;
    logic              rw_reg;
    logic              mack_reg;
    logic              wr_reg;
    logic [7:0]        wr_addr_reg;
    logic [7:0]        wr_data_reg;
    logic [3:0][7:0]   cfg_reg;
    logic [2:0]        wr_slot;
    logic [15:0]       tick_cnt_reg;
    logic              tick_reg;
    logic [6:0]        pwm_cnt_reg;
    logic [LEDS-1:0]   led_reg;
    logic [GROUPS-1:0][6:0] grp_level;
    logic [GROUPS-1:0] grp_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Line edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda_in;
        end
    end

    assign scl_rise  = scl & ~scl_d;
    assign scl_fall  = ~scl & scl_d;
    assign start_det = scl & scl_d & sda_d & ~sda_in;
    assign stop_det  = scl & scl_d & ~sda_d & sda_in;
    assign ptr_inc   = 8'(ptr_reg + 8'h01);

    function automatic logic [7:0] read_reg(input logic [7:0] a,
                                            input logic [3:0][7:0] r);
        logic [2:0] s;
        s = reg_slot(a);
        read_reg = s[2] ? r[s[1:0]] : UNMAPPED_READ;
    endfunction

    assign rd_cur = read_reg(ptr_reg, cfg_reg);
    assign rd_inc = read_reg(ptr_inc, cfg_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Serial slave
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg   <= I2C_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ptr_reg     <= 8'h00;
            oe_reg      <= 1'b0;
            rw_reg      <= 1'b0;
            mack_reg    <= 1'b0;
            wr_reg      <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_reg <= 1'b0;
            if (start_det) begin
                state_reg   <= I2C_ADDR;
                bit_cnt_reg <= 4'h0;
                oe_reg      <= 1'b0;
            end else if (stop_det) begin
                state_reg <= I2C_IDLE;
                oe_reg    <= 1'b0;
            end else if (scl_rise) begin
                case (state_reg)
                    I2C_ADDR, I2C_PTR, I2C_WDATA: begin
                        shift_reg   <= {shift_reg[6:0], sda_in};
                        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                    end
                    I2C_RACK: begin
                        mack_reg <= ~sda_in;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_reg)
                    I2C_ADDR: begin
                        if (bit_cnt_reg == 4'h8) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                state_reg <= I2C_ADDR_ACK;
                                rw_reg    <= shift_reg[0];
                                oe_reg    <= 1'b1;
                            end else begin
                                state_reg <= I2C_IDLE;
                            end
                        end
                    end
                    I2C_ADDR_ACK: begin
                        if (rw_reg) begin
                            state_reg   <= I2C_RDATA;
                            tx_reg      <= rd_cur;
                            oe_reg      <= ~rd_cur[7];
                            bit_cnt_reg <= 4'h1;
                        end else begin
                            state_reg   <= I2C_PTR;
                            oe_reg      <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                        end
                    end
                    I2C_PTR: begin
                        if (bit_cnt_reg == 4'h8) begin
                            ptr_reg   <= shift_reg;
                            oe_reg    <= 1'b1;
                            state_reg <= I2C_PTR_ACK;
                        end
                    end
                    I2C_PTR_ACK, I2C_WACK: begin
                        if (state_reg == I2C_WACK) begin
                            ptr_reg <= ptr_inc;
                        end
                        oe_reg      <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= I2C_WDATA;
                    end
                    I2C_WDATA: begin
                        if (bit_cnt_reg == 4'h8) begin
                            wr_reg      <= 1'b1;
                            wr_addr_reg <= ptr_reg;
                            wr_data_reg <= shift_reg;
                            oe_reg      <= 1'b1;
                            state_reg   <= I2C_WACK;
                        end
                    end
                    I2C_RDATA: begin
                        if (bit_cnt_reg == 4'h8) begin
                            oe_reg    <= 1'b0;
                            state_reg <= I2C_RACK;
                        end else begin
                            oe_reg      <= ~tx_reg[6];
                            tx_reg      <= {tx_reg[6:0], 1'b0};
                            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                        end
                    end
                    I2C_RACK: begin
                        if (mack_reg) begin
                            ptr_reg     <= ptr_inc;
                            tx_reg      <= rd_inc;
                            oe_reg      <= ~rd_inc[7];
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= I2C_RDATA;
                        end else begin
                            state_reg <= I2C_IDLE;
                        end
                    end
                    default: begin
                        oe_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = oe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Settings registers
    assign wr_slot = reg_slot(wr_addr_reg);                        // see R1

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg <= {GROUPS{CFG_RESET}};
        end else if (wr_reg && wr_slot[2]) begin
            cfg_reg[wr_slot[1:0]] <= wr_data_reg;                  // see R1
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Time base and PWM counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg >= 16'(TICK_CYCLES_P - 1)) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= 16'(tick_cnt_reg + 16'h0001);
            tick_reg     <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || pwm_cnt_reg == PWM_LAST) begin
            pwm_cnt_reg <= 7'h00;
        end else begin
            pwm_cnt_reg <= 7'(pwm_cnt_reg + 7'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One engine per group
    generate
        for (genvar g = 0; g < GROUPS; g++) begin : g_grp
            effect_if eif ();
            assign eif.cfg   = cfg_reg[g];
            assign eif.fade  = {fade_time_four, fade_time_three, fade_time_two, fade_time_one};
            assign eif.tick  = tick_reg;
            assign eif.start = effect_start;
            assign grp_level[g] = eif.level;
            assign grp_busy[g]  = eif.busy;
            dim_effect_engine u_eng (
                .clk     (clk),
                .sys_rst (sys_rst),
                .bus     (eif.eng)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // LED drive, group shared
    generate
        for (genvar i = 0; i < LEDS; i++) begin : g_led
            localparam logic [1:0] GRP = led_group(i);
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    led_reg[i] <= 1'b0;
                end else begin
                    led_reg[i] <= (pwm_cnt_reg < grp_level[GRP]);  // see R6
                end
            end
        end
    endgenerate

    assign led_output  = led_reg;
    assign effect_busy = grp_busy;

endmodule // led_power_on_dim_config

// ### bench/led_dim_assertions.sv
// Port-level checker for the power-on dimming settings block
module led_dim_assertions (
    input wire logic                            clk,
    input wire logic                            sys_rst,
    input wire logic                            scl,
    input wire logic                            sda_out,
    input wire logic                            sda_oe,
    input wire logic                            effect_start,
    input wire logic [led_dim_pkg::LEDS-1:0]    led_output,
    input wire logic [led_dim_pkg::GROUPS-1:0]  effect_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    import led_dim_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // Effect sequences
    sequence s_start;
        effect_start;
    endsequence
    sequence s_all_busy;
        effect_busy == 4'hf;
    endsequence
    sequence s_grp1_end;
        $fell(effect_busy[1]);
    endsequence

    AST_START_BUSY: assert property (s_start |=> s_all_busy)
        else $error("start pulse did not make all groups busy");
    AST_BUSY_CAUSE: assert property ($rose(effect_busy[2]) |-> $past(effect_start))
        else $error("group busy rose without start pulse");
    AST_GRP1_SAME: assert property (led_output[3:1] inside {3'h0, 3'h7})
        else $error("group one outputs differ");
    AST_GRP2_SAME: assert property (led_output[6:4] inside {3'h0, 3'h7})
        else $error("group two outputs differ");
    AST_GRP3_SAME: assert property (led_output[9:7] inside {3'h0, 3'h7})
        else $error("group three outputs differ");
    AST_IDLE_DARK0: assert property (!effect_busy[0] [*3] |-> !led_output[0])
        else $error("idle group zero output lit");
    AST_IDLE_DARK9: assert property (!effect_busy[3] [*3] |-> !led_output[9])
        else $error("idle group three output lit");
    AST_END_DARK1: assert property (s_grp1_end |-> ##2 led_output[3:1] == 3'h0)
        else $error("group one lit after effect end");
    AST_OE_RISE: assert property ($rose(sda_oe) |-> !scl)
        else $error("data line pulled while serial clock high");
    AST_OE_FALL: assert property ($fell(sda_oe) |-> !scl)
        else $error("data line released while serial clock high");
    AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
        else $error("open drain output not low");
endmodule // led_dim_assertions

// ### bench/i2c_host_model.sv
// Two-wire link host that configures the settings registers
module i2c_host_model (
    input  wire logic clk,
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Also serves as repeated start
    task automatic start_cond();
        sda_low = 1'b0;
        gap(2);
        scl = 1'b1;
        gap(4);
        sda_low = 1'b1;
        gap(4);
        scl = 1'b0;
        gap(2);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        gap(2);
        scl = 1'b1;
        gap(4);
        sda_low = 1'b0;
        gap(4);
    endtask

    task automatic put_bit(input logic b);
        sda_low = !b;
        gap(4);
        scl = 1'b1;
        gap(4);
        scl = 1'b0;
        gap(1);
    endtask

    // Line released, pull-up gives high unless device pulls
    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        gap(4);
        scl = 1'b1;
        gap(2);
        b = sda;
        gap(2);
        scl = 1'b0;
        gap(1);
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = !b;
    endtask

    task automatic get_byte(output logic [7:0] d, input logic more);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(!more);
    endtask
endmodule // i2c_host_model

// ### bench/tb_top.sv
// Self-checking bench for the power-on dimming settings block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import led_dim_pkg::*;

    localparam int TICK = 20;

    logic                clk, sys_rst, effect_start, scl, host_low, sda_oe, sda_out, ack;
    logic [FADE_W-1:0]   fade_one, fade_two, fade_three, fade_four;
    logic [LEDS-1:0]     led_output;
    logic [GROUPS-1:0]   effect_busy;
    logic [7:0]          img [7];
    logic [7:0]          rd;
    int                  miscompares, total_checks, seed;
    wire                 sda_line = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    led_power_on_dim_config #(.TICK_CYCLES_P(TICK)) led_power_on_dim_config_i (
        .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .effect_start(effect_start), .fade_time_one(fade_one),
        .fade_time_two(fade_two), .fade_time_three(fade_three), .fade_time_four(fade_four),
        .led_output(led_output), .effect_busy(effect_busy));

    i2c_host_model i2c_host_model_i (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda_line));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic int fade_of(input logic [1:0] c);
        return (c == 2'h0) ? 7 : (c == 2'h1) ? 12 : (c == 2'h2) ? 3 : 20;
    endfunction

    function automatic int pct(input logic [2:0] c);
        int t [8] = '{0, 10, 20, 30, 40, 60, 80, 100};
        return t[c];
    endfunction

    task automatic send(input logic [7:0] d);
        i2c_host_model_i.put_byte(d, ack);
        check("ack", ack, 1'b1);
    endtask

    // Burst from the first register, odd slots are unmapped
    task automatic write_img();
        i2c_host_model_i.start_cond();
        send({DEV_ADDR_DEF, 1'b0});
        send(8'h13);
        for (int i = 0; i < 7; i++) send(img[i]);
        i2c_host_model_i.stop_cond();
    endtask

    task automatic read_check(input logic use_img);
        i2c_host_model_i.start_cond();
        send({DEV_ADDR_DEF, 1'b0});
        send(8'h13);
        i2c_host_model_i.start_cond();
        send({DEV_ADDR_DEF, 1'b1});
        for (int i = 0; i < 7; i++) begin
            i2c_host_model_i.get_byte(rd, i < 6);
            check("reg", rd, (use_img && i % 2 == 0) ? img[i] : 8'h00);
        end
        i2c_host_model_i.stop_cond();
    endtask

    task automatic run_effect();
        logic [LEDS-1:0] hist [100];
        int              fall [4];
        int              t, s, ones, idx;
        fall = '{0, 0, 0, 0};
        effect_start = 1'b1;
        @(negedge clk);
        effect_start = 1'b0;
        for (t = 1; t < 3000 && (fall[0] == 0 || fall[1] == 0 || fall[2] == 0 || fall[3] == 0);
             t++) begin
            @(negedge clk);
            for (int g = 0; g < 4; g++) begin
                if (fall[g] == 0 && effect_busy[g] !== 1'b1) begin
                    fall[g] = t;
                    idx = (g == 0) ? 0 : 3 * g - 2;
                    ones = 0;
                    for (int k = 0; k < 100; k++) ones += int'(hist[k][idx]);
                    s = fade_of(img[2*g][2:1]) + fade_of(img[2*g][7:6])
                        + fade_of({1'b0, img[2*g][0]});
                    check("low_duty", ones, pct(img[2*g][5:3]));
                    check("duration", t >= (s - 3) * TICK && t <= s * TICK + 3, 1);
                end
            end
            hist[t % 100] = led_output;
        end
        if (t >= 3000) begin
            miscompares++;
            stop_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        seed = 32'heb60;
        miscompares = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        effect_start = 1'b0;
        fade_one = 16'h0007;
        fade_two = 16'h000c;
        fade_three = 16'h0003;
        fade_four = 16'h0014;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        read_check(1'b0);
        i2c_host_model_i.start_cond();
        i2c_host_model_i.put_byte({DEV_ADDR_DEF ^ 7'h01, 1'b0}, ack);
        check("foreign_addr_ack", ack, 1'b0);
        i2c_host_model_i.stop_cond();
        for (int run = 0; run < 8; run++) begin
            for (int g = 0; g < 4; g++) begin
                img[2*g] = {2'(run + g), 3'(run + g), 2'(run + 3 * g), 1'($random(seed))};
                if (g < 3) img[2*g+1] = 8'($random(seed));
            end
            write_img();
            read_check(1'b1);
            run_effect();
        end
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        read_check(1'b0);
        stop_test();
    end
endmodule // tb_top

bind led_power_on_dim_config led_dim_assertions led_dim_assertions_i (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
    .effect_start(effect_start), .led_output(led_output), .effect_busy(effect_busy));
